// File: hw/ofl_pkg.sv
// Package for the output frequency limiter: register map, field layouts, reset values
package ofl_pkg;
  // Frequencies are held in units of 0.01 Hz, 16 bits wide
  localparam int unsigned FW = 16;
  typedef logic [FW-1:0] ofl_freq_t;

  // Setting values
  localparam ofl_freq_t FREQ_120HZ  = 16'h2ee0; // 120.00 Hz
  localparam ofl_freq_t FREQ_400HZ  = 16'h9c40; // 400.00 Hz
  localparam ofl_freq_t FREQ_ZERO   = 16'h0000;
  localparam ofl_freq_t JUMP_OFF    = 16'h270f; // 9999 disables a jump setting
  localparam ofl_freq_t STEP_RESET  = 16'h0001; // Ramp step per tick after reset

  // Register byte offsets
  localparam logic [7:0] A_UPPER    = 8'h00;
  localparam logic [7:0] A_LOWER    = 8'h04;
  localparam logic [7:0] A_HIGHSPD  = 8'h08;
  localparam logic [7:0] A_JOG      = 8'h0c;
  localparam logic [7:0] A_START    = 8'h10;
  localparam logic [7:0] A_J1A      = 8'h14;
  localparam logic [7:0] A_J1B      = 8'h18;
  localparam logic [7:0] A_J2A      = 8'h1c;
  localparam logic [7:0] A_J2B      = 8'h20;
  localparam logic [7:0] A_J3A      = 8'h24;
  localparam logic [7:0] A_J3B      = 8'h28;
  localparam logic [7:0] A_CMD      = 8'h2c;
  localparam logic [7:0] A_CTRL     = 8'h30;
  localparam logic [7:0] A_STEP     = 8'h34;
  localparam logic [7:0] A_TARGET   = 8'h38;
  localparam logic [7:0] A_OUT      = 8'h3c;
  localparam logic [7:0] A_STATUS   = 8'h40;

  // Control register bits
  localparam int unsigned C_START   = 0;
  localparam int unsigned C_JOG     = 1;
  localparam int unsigned C_CMDVAL  = 2;

  // Status register bits
  localparam int unsigned S_STEADY  = 0;
  localparam int unsigned S_ACCEL   = 1;
  localparam int unsigned S_DECEL   = 2;
  localparam int unsigned S_JOGRUN  = 3;

  // Ramp state
  typedef enum logic [1:0] {OFL_STEADY, OFL_ACCEL, OFL_DECEL} ofl_ramp_e;

  // APB request carrier
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } ofl_apb_req_s;

  // APB answer carrier
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } ofl_apb_rsp_s;
endpackage : ofl_pkg

// File: hw/ofl_limiter.sv
// Output frequency limiter: clamps, high-speed ceiling, jump bands and output ramp
`timescale 1ns/1ps
`default_nettype none
// What this block does
// [R1] Output frequency is clamped at the upper limit; setting 0..120 Hz, reset 120 Hz.
// [R2] Output frequency held at or above lower limit; setting 0..120 Hz, reset 0.
// [R3] High-speed upper limit 120..400 Hz, reset 120 Hz, is the output ceiling.
// [R4] Writing either upper limit copies the value into the other.
// [R5] Jog at or below lower limit runs at jog frequency, bypassing lower clamp.
// [R6] Start alone, lower limit above starting frequency, ramps up to lower limit.
// [R7] Three jump bands, settings 0..400 Hz, 9999 disables and is reset value.
// [R8] Command inside an enabled band runs steadily at the band's first setting.
// [R9] Software picks jump at top or bottom by ordering first and second settings.
// [R10] Ramping passes through band frequencies; only the steady target is substituted.
// [R11] Clamps precede band checks; target updates one cycle after any change.
module ofl_limiter
  import ofl_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire ofl_pkg::ofl_apb_req_s apb_req,
  output var  ofl_pkg::ofl_apb_rsp_s apb_rsp,
  output var  ofl_pkg::ofl_freq_t    out_freq,
  output var  ofl_pkg::ofl_freq_t    target_freq,
  output var  logic                  running
);
  import ofl_pkg::*;

  // Settings and command registers
  ofl_freq_t upper_freq_limit_q;
  ofl_freq_t lower_freq_limit_q;
  ofl_freq_t high_speed_upper_limit_q;
  ofl_freq_t jog_freq_setting_q;
  ofl_freq_t starting_freq_setting_q;
  ofl_freq_t jump_first_q  [3];
  ofl_freq_t jump_second_q [3];
  ofl_freq_t cmd_freq_q;
  ofl_freq_t step_q;
  logic [2:0] ctrl_q;
  ofl_freq_t target_q;
  ofl_freq_t out_q;
  ofl_ramp_e ramp_q;
  ofl_apb_rsp_s rsp_q;
  logic      running_q;

  // Range check for a jump setting: 0..400 Hz or the disable code
  function automatic logic jump_ok(input ofl_freq_t v);
    jump_ok = (v <= FREQ_400HZ) || (v == JUMP_OFF);
  endfunction

  // Band membership: inclusive, either order of the two settings
  function automatic logic in_band(input ofl_freq_t f, input ofl_freq_t a, input ofl_freq_t b);
    logic on;
    on = (a != JUMP_OFF) && (b != JUMP_OFF);
    if (a <= b)
      in_band = on && (f >= a) && (f <= b);
    else
      in_band = on && (f >= b) && (f <= a);
  endfunction

  // Bus decode
  wire logic      acc     = apb_req.psel && apb_req.penable;
  wire logic      wr      = acc && apb_req.pwrite;
  wire logic [7:0] adr    = apb_req.paddr;
  wire ofl_freq_t wv      = apb_req.pwdata[FW-1:0];
  wire logic      wr_up   = wr && (adr == A_UPPER);
  wire logic      wr_hs   = wr && (adr == A_HIGHSPD);
  wire logic      up_ok   = wv <= FREQ_120HZ;
  wire logic      hs_ok   = (wv >= FREQ_120HZ) && (wv <= FREQ_400HZ);
  wire logic      mapped  = (adr <= A_STATUS) && (adr[1:0] == 2'b00);

  // Command conditioning
  wire logic      start_r = ctrl_q[C_START];
  wire logic      jog_r   = ctrl_q[C_JOG];
  wire logic      cmd_v   = ctrl_q[C_CMDVAL];
  // Active ceiling: the lower of the two upper settings, both mirrored on write
  wire ofl_freq_t ceil_f  = (upper_freq_limit_q < high_speed_upper_limit_q)
                            ? upper_freq_limit_q : high_speed_upper_limit_q;
  // [R6] start only: no command counts as zero, clamp lifts it to the lower limit
  wire ofl_freq_t raw_f   = cmd_v ? cmd_freq_q : FREQ_ZERO;
  // [R1] upper clamp, [R3] high-speed ceiling
  wire ofl_freq_t up_f    = (raw_f > ceil_f) ? ceil_f : raw_f;
  // [R2] lower clamp
  wire ofl_freq_t lo_f    = (up_f < lower_freq_limit_q) ? lower_freq_limit_q : up_f;
  // [R11] bands judged on the clamped value
  wire logic      hit1    = in_band(lo_f, jump_first_q[0], jump_second_q[0]);
  wire logic      hit2    = in_band(lo_f, jump_first_q[1], jump_second_q[1]);
  wire logic      hit3    = in_band(lo_f, jump_first_q[2], jump_second_q[2]);
  // [R8] first setting is the jump point; band 1 has priority
  wire ofl_freq_t jmp_f   = hit1 ? jump_first_q[0] : hit2 ? jump_first_q[1]
                            : hit3 ? jump_first_q[2] : lo_f;
  // [R5] jog at or below lower limit bypasses lower clamp
  wire logic      jog_byp = jog_r && (jog_freq_setting_q <= lower_freq_limit_q);
  wire ofl_freq_t jog_f   = jog_byp ? jog_freq_setting_q
                            : ((jog_freq_setting_q > ceil_f) ? ceil_f
                               : (jog_freq_setting_q < lower_freq_limit_q)
                                 ? lower_freq_limit_q : jog_freq_setting_q);
  wire ofl_freq_t tgt_d   = jog_r ? jog_f : (start_r ? jmp_f : FREQ_ZERO);

  // Ramp arithmetic, saturating at the target
  wire ofl_freq_t gap_up  = target_q - out_q;
  wire ofl_freq_t gap_dn  = out_q - target_q;
  wire ofl_freq_t up_nx   = (gap_up > step_q) ? ofl_freq_t'(out_q + step_q) : target_q;
  wire ofl_freq_t dn_nx   = (gap_dn > step_q) ? ofl_freq_t'(out_q - step_q) : target_q;
  wire ofl_freq_t out_d   = (out_q < target_q) ? up_nx : (out_q > target_q) ? dn_nx : out_q;
  wire ofl_ramp_e ramp_d  = (out_d < target_q) ? OFL_ACCEL
                            : (out_d > target_q) ? OFL_DECEL : OFL_STEADY;
  // Run indication from next-state values, so the pin can come from a flop
  // without lagging the output frequency by a cycle
  wire logic      run_d   = (out_d != FREQ_ZERO) || (ramp_d != OFL_STEADY);

  // Read mux
  ofl_freq_t rd_f;
  wire logic [3:0] stat_w = {jog_r, ramp_q == OFL_DECEL, ramp_q == OFL_ACCEL,
                             ramp_q == OFL_STEADY};
  always_comb
  begin
    rd_f = FREQ_ZERO;
    case (adr)
      A_UPPER:   rd_f = upper_freq_limit_q;
      A_LOWER:   rd_f = lower_freq_limit_q;
      A_HIGHSPD: rd_f = high_speed_upper_limit_q;
      A_JOG:     rd_f = jog_freq_setting_q;
      A_START:   rd_f = starting_freq_setting_q;
      A_J1A:     rd_f = jump_first_q[0];
      A_J1B:     rd_f = jump_second_q[0];
      A_J2A:     rd_f = jump_first_q[1];
      A_J2B:     rd_f = jump_second_q[1];
      A_J3A:     rd_f = jump_first_q[2];
      A_J3B:     rd_f = jump_second_q[2];
      A_CMD:     rd_f = cmd_freq_q;
      A_CTRL:    rd_f = {13'h0, ctrl_q};
      A_STEP:    rd_f = step_q;
      A_TARGET:  rd_f = target_q;
      A_OUT:     rd_f = out_q;
      A_STATUS:  rd_f = {12'h0, stat_w};
      default:   rd_f = FREQ_ZERO;
    endcase
  end

  // APB answer: no wait state, registered; unmapped gives pslverr
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rsp_q <= '0;
    else if (apb_req.psel && !apb_req.penable)
    begin
      rsp_q.pready  <= 1'b1;
      rsp_q.pslverr <= !mapped;
      rsp_q.prdata  <= {16'h0000, rd_f};
    end
    else
      rsp_q <= '0;
  end

  // Write commit happens only on the access edge where pready is high
  wire logic commit = wr && rsp_q.pready;

  // Upper limits, mirrored on write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // [R1] [R3] reset to 120 Hz
      upper_freq_limit_q       <= FREQ_120HZ;
      high_speed_upper_limit_q <= FREQ_120HZ;
    end
    // [R4] normal write copies into high-speed
    else if (commit && wr_up && up_ok)
    begin
      upper_freq_limit_q       <= wv;
      high_speed_upper_limit_q <= wv;
    end
    // [R4] high-speed write copies into normal
    else if (commit && wr_hs && hs_ok)
    begin
      upper_freq_limit_q       <= wv;
      high_speed_upper_limit_q <= wv;
    end
  end

  // Other settings; out-of-range values are ignored
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lower_freq_limit_q      <= FREQ_ZERO;
      jog_freq_setting_q      <= FREQ_ZERO;
      starting_freq_setting_q <= FREQ_ZERO;
      cmd_freq_q              <= FREQ_ZERO;
      ctrl_q                  <= 3'h0;
      step_q                  <= STEP_RESET;
      // [R7] bands disabled at reset
      jump_first_q            <= '{JUMP_OFF, JUMP_OFF, JUMP_OFF};
      jump_second_q           <= '{JUMP_OFF, JUMP_OFF, JUMP_OFF};
    end
    else if (commit)
    begin
      case (adr)
        // [R2] lower limit range 0..120 Hz
        A_LOWER: if (up_ok) lower_freq_limit_q <= wv;
        A_JOG:   if (wv <= FREQ_400HZ) jog_freq_setting_q <= wv;
        A_START: if (wv <= FREQ_400HZ) starting_freq_setting_q <= wv;
        // [R7] jump settings 0..400 Hz or 9999
        A_J1A:   if (jump_ok(wv)) jump_first_q[0]  <= wv;
        A_J1B:   if (jump_ok(wv)) jump_second_q[0] <= wv;
        A_J2A:   if (jump_ok(wv)) jump_first_q[1]  <= wv;
        A_J2B:   if (jump_ok(wv)) jump_second_q[1] <= wv;
        A_J3A:   if (jump_ok(wv)) jump_first_q[2]  <= wv;
        A_J3B:   if (jump_ok(wv)) jump_second_q[2] <= wv;
        A_CMD:   cmd_freq_q <= wv;
        A_CTRL:  ctrl_q     <= apb_req.pwdata[2:0];
        A_STEP:  if (wv != FREQ_ZERO) step_q <= wv;
        default: ;
      endcase
    end
  end

  // Target register and ramp
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      target_q <= FREQ_ZERO;
      out_q    <= FREQ_ZERO;
      ramp_q   <= OFL_STEADY;
      running_q <= 1'b0;
    end
    else
    begin
      // [R11] target follows inputs one cycle later
      target_q <= tgt_d;
      // [R10] ramp passes through band frequencies
      out_q    <= out_d;
      ramp_q   <= ramp_d;
      running_q <= run_d;
    end
  end

  // Outputs
  assign apb_rsp     = rsp_q;
  assign out_freq    = out_q;
  assign target_freq = target_q;
  assign running     = running_q;
endmodule : ofl_limiter
`default_nettype wire

// File: test/ofl_apb_src.sv
// APB command source that drives the limiter's register bus
`timescale 1ns/1ps
`default_nettype none
module ofl_apb_src
  import ofl_pkg::*;
(
  input  wire logic                  pclk,
  output var  ofl_pkg::ofl_apb_req_s req,
  input  wire ofl_pkg::ofl_apb_rsp_s rsp
);
  import ofl_pkg::*;
  initial req = '0;
  // One transfer: setup, access held until pready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    req <= '{1'b1, 1'b0, w, a, {16'h0000, d}};
    @(posedge pclk);
    req.penable <= 1'b1;
    // Access held until pready is seen high; only the bench timeout ends a hang
    @(posedge pclk);
    while (rsp.pready !== 1'b1)
      @(posedge pclk);
    q = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
  endtask
endmodule // ofl_apb_src
`default_nettype wire

// File: test/ofl_limiter_checker.sv
// Port checks for the output frequency limiter
`timescale 1ns/1ps
`default_nettype none
module ofl_limiter_checker
  import ofl_pkg::*;
(
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire ofl_pkg::ofl_apb_req_s apb_req,
  input wire ofl_pkg::ofl_apb_rsp_s apb_rsp,
  input wire ofl_pkg::ofl_freq_t    out_freq,
  input wire ofl_pkg::ofl_freq_t    target_freq,
  input wire logic                  running
);
  import ofl_pkg::*;
  // Bus phase decodes
  wire setup = apb_req.psel && !apb_req.penable;
  wire wacc  = apb_req.psel && apb_req.penable && apb_req.pwrite;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ans_one_a: assert property (setup |=> apb_rsp.pready ##1 !apb_rsp.pready)
    else $error("pready is not a one-cycle answer");
  err_map_a: assert property (setup && apb_req.paddr > 8'h40 |=> apb_rsp.pslverr)
    else $error("unmapped address not refused");
  hi_word_a: assert property (apb_rsp.pready |-> apb_rsp.prdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  ceil_tgt_a: assert property (target_freq <= FREQ_400HZ)
    else $error("target above ceiling");
  ceil_out_a: assert property (out_freq <= FREQ_400HZ)
    else $error("output above ceiling");
  tgt_cause_a: assert property ($changed(target_freq) |-> $past(wacc) || $past(wacc, 2))
    else $error("target moved without a write");
  run_out_a: assert property (out_freq != 16'h0000 |-> running)
    else $error("running low with output nonzero");
  no_over_a: assert property (out_freq <= target_freq && $stable(target_freq)
    |=> out_freq <= $past(target_freq))
    else $error("ramp overshoots target");
  ramp_go_a: assert property ((out_freq < target_freq) [*3] |-> out_freq > $past(out_freq, 2))
    else $error("ramp stalled below target");
  steady_a: assert property (out_freq == target_freq && $stable(target_freq)
    |=> $stable(out_freq))
    else $error("output left steady target");
endmodule // ofl_limiter_checker
bind ofl_limiter ofl_limiter_checker i_ofl_limiter_checker (.pclk(pclk), .presetn(presetn),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .out_freq(out_freq), .target_freq(target_freq),
  .running(running));
`default_nettype wire

// File: test/tb.sv
// Self-checking bench for the output frequency limiter
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ofl_pkg::*;
  logic         pclk;
  logic         presetn;
  ofl_apb_req_s req;
  ofl_apb_rsp_s rsp;
  ofl_freq_t    out_freq;
  ofl_freq_t    target_freq;
  logic         running;
  logic [31:0]  q;
  logic         e;
  int           fails = 0;
  int           checked = 0;
  int           cyc = 0;
  ofl_limiter i_ofl_limiter (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .out_freq(out_freq), .target_freq(target_freq), .running(running));
  ofl_apb_src src (.pclk(pclk), .req(req), .rsp(rsp));
  // Clock
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // Hang guard
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      fails++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x)
    begin
      fails++;
      $display("MISMATCH %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    src.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] x);
    src.xfer(1'b0, a, 16'h0000, q, e);
    chk(q, {16'h0000, x});
  endtask
  // Let a setting land, then look at the target
  task automatic tchk(input ofl_freq_t x);
    repeat (2) @(posedge pclk);
    #1;
    chk({16'h0000, target_freq}, {16'h0000, x});
  endtask
  task automatic settle();
    int n;
    n = 0;
    while (out_freq !== target_freq && n < 1000)
    begin
      n++;
      @(posedge pclk);
      #1;
    end
    if (n >= 1000)
    begin
      fails++;
      $display("MISMATCH %0t ramp did not settle", $time);
    end
  endtask
  task automatic t_reset();
    rchk(A_UPPER, FREQ_120HZ);
    rchk(A_LOWER, FREQ_ZERO);
    rchk(A_HIGHSPD, FREQ_120HZ);
    for (int i = 0; i < 6; i++)
      rchk(A_J1A + 8'(4 * i), JUMP_OFF);
    chk({16'h0000, target_freq}, 32'h0);
    chk({16'h0000, out_freq}, 32'h0);
    chk(32'(running), 32'h0);
  endtask
  task automatic t_limits();
    wr(A_STEP, 16'h0064);
    wr(A_CTRL, 16'h0005);
    wr(A_CMD, 16'h32c8); // 130 Hz command
    tchk(FREQ_120HZ);
    wr(A_UPPER, 16'h3a98); // 150 Hz is out of range
    rchk(A_UPPER, FREQ_120HZ);
    wr(A_HIGHSPD, 16'h7530);
    rchk(A_UPPER, 16'h7530);
    wr(A_CMD, 16'h88b8);
    tchk(16'h7530);
    wr(A_UPPER, FREQ_120HZ);
    rchk(A_HIGHSPD, FREQ_120HZ);
    tchk(FREQ_120HZ);
    wr(A_LOWER, 16'h0bb8);
    wr(A_CMD, 16'h03e8);
    tchk(16'h0bb8);
    src.xfer(1'b0, 8'h44, 16'h0000, q, e);
    chk(32'(e), 32'h1);
  endtask
  task automatic t_jog_start();
    wr(A_JOG, 16'h07d0); // Jog below lower limit
    wr(A_CTRL, 16'h0002);
    tchk(16'h07d0);
    wr(A_CTRL, 16'h0001); // Start with no command
    tchk(16'h0bb8);
    settle();
    chk({16'h0000, out_freq}, 32'h0bb8);
    chk(32'(running), 32'h1);
  endtask
  task automatic t_jump();
    logic [7:0] a;
    wr(A_LOWER, FREQ_ZERO);
    wr(A_CTRL, 16'h0005);
    wr(A_CMD, 16'h1194); // 45 Hz inside 40..50
    for (int b = 0; b < 3; b++)
    begin
      a = A_J1A + 8'(8 * b);
      wr(a, 16'h0fa0);
      wr(a + 8'h04, 16'h1388);
      tchk(16'h0fa0);
      wr(a, 16'h1388);
      wr(a + 8'h04, 16'h0fa0);
      tchk(16'h1388);
      wr(a, JUMP_OFF);
      tchk(16'h1194);
    end
  endtask
  task automatic t_pass();
    logic seen;
    seen = 1'b0;
    wr(A_J1A, 16'h0fa0);
    wr(A_J1B, 16'h1388);
    wr(A_CMD, 16'h0064);
    tchk(16'h0064);
    settle();
    wr(A_CMD, 16'h1770);
    repeat (80)
    begin
      @(posedge pclk);
      #1;
      if (out_freq > 16'h0fa0 && out_freq < 16'h1388)
        seen = 1'b1;
    end
    chk(32'(seen), 32'h1);
    chk({16'h0000, out_freq}, 32'h1770);
    wr(A_CTRL, 16'h0000); // Stop: no start, no jog
    tchk(FREQ_ZERO);
    settle();
    chk(32'(running), 32'h0);
    rchk(A_STATUS, 16'h0001);
  endtask
  task automatic final_report();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    presetn = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_limits();
    t_jog_start();
    t_jump();
    t_pass();
    final_report();
  end
endmodule // tb
`default_nettype wire
